// ===== src/cws_pkg.sv
// constants, offsets, field layout and states of the control write sequencer
package cws_pkg;
   localparam int unsigned IDX_W = 9;
   localparam int unsigned STEP_COUNT = 510;
   localparam int unsigned REG_DW = 16;
   localparam int unsigned TGT_AW = 13;
   localparam int unsigned WAIT_W = 4;
   localparam int unsigned CNT_W = 26;

   // register offsets on the register access port
   localparam logic [15:0] GPIO_TRIG_ENA_OFS = 16'h0041;
   localparam logic [15:0] PIN1_RISE_OFS = 16'h0068;
   localparam logic [15:0] PIN1_FALL_OFS = 16'h0069;
   localparam logic [15:0] PIN2_RISE_OFS = 16'h006A;
   localparam logic [15:0] PIN2_FALL_OFS = 16'h006B;
   localparam logic [15:0] STEP_BASE_OFS = 16'h3000;
   localparam logic [15:0] STEP_LAST_OFS = 16'h33FB;

   // field positions of the gpio trigger enable register
   localparam int unsigned PIN1_ENA_BIT = 0;
   localparam int unsigned PIN2_ENA_BIT = 1;

   // step word: low half is register 2n, high half is register 2n+1
   localparam int unsigned STEP_ADDR_LSB = 0;
   localparam int unsigned STEP_WIDTH_LSB = 13;
   localparam int unsigned STEP_DATA_LSB = 16;
   localparam int unsigned STEP_FLSB_LSB = 24;
   localparam int unsigned STEP_WAIT_LSB = 28;

   // reset values and special codes
   localparam logic [IDX_W-1:0] FIRST_STEP_RESET = 9'h1FF;
   localparam logic [IDX_W-1:0] IDX_DISABLED = 9'h1FF;
   localparam logic [IDX_W-1:0] IDX_LAST_VALID = 9'h1FD;
   localparam logic [1:0] TRIG_ENA_RESET = 2'h0;
   localparam logic [WAIT_W-1:0] WAIT_MIN_CODE = 4'h0;
   localparam logic [WAIT_W-1:0] WAIT_LAST_CODE = 4'hF;

   // timing
   localparam longint unsigned CLK_MHZ = 20;
   localparam longint unsigned STEP_MIN_NS = 3300;
   localparam longint unsigned DELAY_UNIT_NS = 61440;
   localparam longint unsigned STEP_MIN_CYC = (STEP_MIN_NS * CLK_MHZ + 999) / 1000;

   // sequencer states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,
      ST_FETCH  = 6'h02,
      ST_LOAD   = 6'h04,
      ST_READ   = 6'h08,
      ST_MODIFY = 6'h10,
      ST_WAIT   = 6'h20
   } cws_state_e;
endpackage

// ===== src/cws_mem_if.sv
// carrier between the sequencer core and its step memory
`timescale 1ns/1ps
interface cws_mem_if #(
   parameter int unsigned IDX_W = 9
);
   logic [IDX_W-1:0] wr_idx;
   logic [1:0] wr_half;
   logic [15:0] wr_data;
   logic [IDX_W-1:0] host_idx;
   logic [31:0] host_data;
   logic [IDX_W-1:0] seq_idx;
   logic [31:0] seq_data;

   modport ctrl (
      output wr_idx,
      output wr_half,
      output wr_data,
      output host_idx,
      output seq_idx,
      input host_data,
      input seq_data
   );
   modport store (
      input wr_idx,
      input wr_half,
      input wr_data,
      input host_idx,
      input seq_idx,
      output host_data,
      output seq_data
   );
endinterface

// ===== src/cws_step_mem.sv
// step memory with one write port and two registered read ports
`timescale 1ns/1ps
module cws_step_mem
   import cws_pkg::*;
#(
   parameter int unsigned DEPTH = STEP_COUNT
) (
   input wire logic core_clk,
   cws_mem_if.store bus
);
   logic [31:0] mem [DEPTH];

   // contents carry no reset so they survive every reset
   always_ff @(posedge core_clk) begin
      if (32'(bus.wr_idx) < DEPTH) begin
         if (bus.wr_half[0]) begin
            mem[bus.wr_idx][15:0] <= bus.wr_data;
         end
         if (bus.wr_half[1]) begin
            mem[bus.wr_idx][31:16] <= bus.wr_data;
         end
      end
   end

   // read data straight from registers
   always_ff @(posedge core_clk) begin
      bus.host_data <= (32'(bus.host_idx) < DEPTH) ? mem[bus.host_idx] : 32'h0000_0000;
      bus.seq_data <= (32'(bus.seq_idx) < DEPTH) ? mem[bus.seq_idx] : 32'h0000_0000;
   end
endmodule

// ===== src/cws_sequencer.sv
// control write sequencer: triggers, request queue, step engine and registers
`timescale 1ns/1ps
module cws_sequencer
   import cws_pkg::*;
#(
   parameter int unsigned NPATH = 2,
   parameter int unsigned QDEPTH = 8,
   parameter longint unsigned DELAY_UNIT = DELAY_UNIT_NS,
   parameter logic [NPATH*IDX_W-1:0] PATH_UP_FIRST = {9'h010, 9'h000},
   parameter logic [NPATH*IDX_W-1:0] PATH_DOWN_FIRST = {9'h030, 9'h020}
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [15:0] reg_addr,
   input wire logic [REG_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [REG_DW-1:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic sequencer_global_enable,
   input wire logic [IDX_W-1:0] host_sequence_first_step,
   input wire logic host_launch_bit,
   input wire logic stop_current_sequence,
   output logic sequencer_running_flag,
   output logic [IDX_W-1:0] last_step_executed,
   output logic seq_done_flag,
   input wire logic seq_done_clear,
   input wire logic [NPATH-1:0] out_path_ena,
   input wire logic [IDX_W-1:0] rate_a_first_step,
   input wire logic [IDX_W-1:0] rate_b_first_step,
   input wire logic [IDX_W-1:0] rate_c_first_step,
   input wire logic [IDX_W-1:0] rate_d_first_step,
   input wire logic [3:0] rate_detect,
   input wire logic audio_serial_port_slave,
   input wire logic rate_estimation_enable,
   input wire logic [1:0] gpio_in,
   output logic [TGT_AW-1:0] tgt_addr,
   output logic tgt_rd,
   input wire logic [REG_DW-1:0] tgt_rdata,
   output logic tgt_wr,
   output logic [REG_DW-1:0] tgt_wdata
);
   localparam int unsigned NSRC = 9 + 2 * NPATH;
   localparam int unsigned QP_W = $clog2(QDEPTH);

   if (NPATH < 1 || QDEPTH < 2 || (QDEPTH & (QDEPTH - 1)) != 0) begin : g_bad
      $error("cws_sequencer: NPATH >= 1 and QDEPTH a power of two >= 2");
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers and step memory access

   logic [1:0] trig_ena;
   logic [IDX_W-1:0] pin1_rise_first_step;
   logic [IDX_W-1:0] pin1_fall_first_step;
   logic [IDX_W-1:0] pin2_rise_first_step;
   logic [IDX_W-1:0] pin2_fall_first_step;
   logic in_step_range;
   logic rd_pend;
   logic rd_is_mem;
   logic rd_half;
   logic [REG_DW-1:0] rd_small;
   logic [IDX_W-1:0] cur_idx;

   cws_mem_if #(.IDX_W(IDX_W)) mem_bus ();

   cws_step_mem #(.DEPTH(STEP_COUNT)) u_mem (
      .core_clk(core_clk),
      .bus(mem_bus.store)
   );

   // step registers map onto memory index and half
   assign in_step_range = (reg_addr >= STEP_BASE_OFS) && (reg_addr <= STEP_LAST_OFS);
   assign mem_bus.wr_idx = reg_addr[IDX_W:1];
   assign mem_bus.wr_half = {2{reg_wr & in_step_range}} & {reg_addr[0], ~reg_addr[0]};
   assign mem_bus.wr_data = reg_wdata;
   assign mem_bus.host_idx = reg_addr[IDX_W:1];
   assign mem_bus.seq_idx = cur_idx;

   // control register writes
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         trig_ena <= TRIG_ENA_RESET;
         pin1_rise_first_step <= FIRST_STEP_RESET;
         pin1_fall_first_step <= FIRST_STEP_RESET;
         pin2_rise_first_step <= FIRST_STEP_RESET;
         pin2_fall_first_step <= FIRST_STEP_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            GPIO_TRIG_ENA_OFS: trig_ena <= reg_wdata[PIN2_ENA_BIT:PIN1_ENA_BIT];
            PIN1_RISE_OFS: pin1_rise_first_step <= reg_wdata[IDX_W-1:0];
            PIN1_FALL_OFS: pin1_fall_first_step <= reg_wdata[IDX_W-1:0];
            PIN2_RISE_OFS: pin2_rise_first_step <= reg_wdata[IDX_W-1:0];
            PIN2_FALL_OFS: pin2_fall_first_step <= reg_wdata[IDX_W-1:0];
            default: ;
         endcase
      end
   end

   // read stage one: pick the small register value
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rd_pend <= 1'b0;
         rd_is_mem <= 1'b0;
         rd_half <= 1'b0;
         rd_small <= 16'h0000;
      end else begin
         rd_pend <= reg_rd;
         rd_is_mem <= in_step_range;
         rd_half <= reg_addr[0];
         case (reg_addr)
            GPIO_TRIG_ENA_OFS: rd_small <= {14'h0000, trig_ena};
            PIN1_RISE_OFS: rd_small <= {7'h00, pin1_rise_first_step};
            PIN1_FALL_OFS: rd_small <= {7'h00, pin1_fall_first_step};
            PIN2_RISE_OFS: rd_small <= {7'h00, pin2_rise_first_step};
            PIN2_FALL_OFS: rd_small <= {7'h00, pin2_fall_first_step};
            default: rd_small <= 16'h0000;
         endcase
      end
   end

   // read stage two: answer two cycles after the strobe
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= rd_pend;
         if (rd_pend) begin
            reg_rdata <= rd_is_mem ? (rd_half ? mem_bus.host_data[31:16]
                                              : mem_bus.host_data[15:0]) : rd_small;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // trigger sources

   logic [1:0] gpio_meta;
   logic [1:0] gpio_sync;
   logic [1:0] gpio_prev;
   logic [NPATH-1:0] path_prev;
   logic [NSRC-1:0] trig;
   logic [IDX_W-1:0] src_idx [NSRC];
   logic rate_ok;

   // two-stage synchroniser then edge history
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         gpio_meta <= 2'h0;
         gpio_sync <= 2'h0;
         gpio_prev <= 2'h0;
         path_prev <= '0;
      end else begin
         gpio_meta <= gpio_in;
         gpio_sync <= gpio_meta;
         gpio_prev <= gpio_sync;
         path_prev <= out_path_ena;
      end
   end

   assign rate_ok = audio_serial_port_slave & rate_estimation_enable;

   // source table: host, four rates, four gpio edges, then path up and down
   always_comb begin
      trig = '0;
      trig[0] = host_launch_bit;
      trig[4:1] = rate_detect & {4{rate_ok}};
      trig[5] = trig_ena[0] & gpio_sync[0] & ~gpio_prev[0];
      trig[6] = trig_ena[0] & ~gpio_sync[0] & gpio_prev[0];
      trig[7] = trig_ena[1] & gpio_sync[1] & ~gpio_prev[1];
      trig[8] = trig_ena[1] & ~gpio_sync[1] & gpio_prev[1];
      src_idx[0] = host_sequence_first_step;
      src_idx[1] = rate_a_first_step;
      src_idx[2] = rate_b_first_step;
      src_idx[3] = rate_c_first_step;
      src_idx[4] = rate_d_first_step;
      src_idx[5] = pin1_rise_first_step;
      src_idx[6] = pin1_fall_first_step;
      src_idx[7] = pin2_rise_first_step;
      src_idx[8] = pin2_fall_first_step;
      for (int p = 0; p < NPATH; p++) begin
         trig[9 + 2 * p] = out_path_ena[p] & ~path_prev[p];
         trig[10 + 2 * p] = ~out_path_ena[p] & path_prev[p];
         src_idx[9 + 2 * p] = PATH_UP_FIRST[p * IDX_W +: IDX_W];
         src_idx[10 + 2 * p] = PATH_DOWN_FIRST[p * IDX_W +: IDX_W];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pending requests and the ordered queue

   logic [NSRC-1:0] pend;
   logic [NSRC-1:0] grant;
   logic [IDX_W-1:0] grant_idx;
   logic [IDX_W-1:0] queue [QDEPTH];
   logic [QP_W-1:0] q_wr;
   logic [QP_W-1:0] q_rd;
   logic [QP_W:0] q_cnt;
   logic q_full;
   logic q_push;
   logic q_pop;
   cws_state_e state;

   assign q_full = (q_cnt == (QP_W + 1)'(QDEPTH));
   assign q_pop = (state == ST_IDLE) && (q_cnt != '0);

   // lowest pending source is moved first, one per cycle
   always_comb begin
      grant = '0;
      grant_idx = '0;
      for (int s = NSRC - 1; s >= 0; s--) begin
         if (pend[s]) begin
            grant = '0;
            grant[s] = 1'b1;
            grant_idx = src_idx[s];
         end
      end
   end

   assign q_push = (grant != '0) && !q_full && (grant_idx != IDX_DISABLED);

   // new triggers win over the clear of a granted one
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pend <= '0;
      end else begin
         pend <= (pend & ~(q_full ? '0 : grant)) | (trig & {NSRC{sequencer_global_enable}});
      end
   end

   // queue storage and pointers
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         q_wr <= '0;
         q_rd <= '0;
         q_cnt <= '0;
         for (int i = 0; i < QDEPTH; i++) begin
            queue[i] <= '0;
         end
      end else begin
         if (q_push) begin
            queue[q_wr] <= grant_idx;
            q_wr <= q_wr + 1'b1;
         end
         if (q_pop) begin
            q_rd <= q_rd + 1'b1;
         end
         q_cnt <= q_cnt + (QP_W + 1)'(q_push) - (QP_W + 1)'(q_pop);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // step engine

   logic [CNT_W-1:0] wait_cnt;
   logic [3:0] st_width;
   logic [3:0] st_flsb;
   logic [7:0] st_data;
   logic [WAIT_W-1:0] st_wait;
   logic [REG_DW-1:0] field_mask;
   logic seq_end;

   // total step time in cycles, rounded up
   function automatic logic [CNT_W-1:0] wait_cycles(input logic [WAIT_W-1:0] code);
      longint unsigned cyc;
      if (code == WAIT_MIN_CODE || code == WAIT_LAST_CODE) begin
         cyc = STEP_MIN_CYC;
      end else begin
         cyc = (DELAY_UNIT * ((64'd1 << code) - 64'd1) * CLK_MHZ + 999) / 1000;
      end
      return CNT_W'(cyc);
   endfunction

   // mask covers width bits starting at the field lsb
   assign field_mask = 16'((17'h00001 << st_width) - 17'h00001) << st_flsb;
   assign seq_end = (st_wait == WAIT_LAST_CODE) || (cur_idx >= IDX_LAST_VALID);

   // sequencing: fetch, read target, merge field, write, wait
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state <= ST_IDLE;
         cur_idx <= '0;
         wait_cnt <= '0;
         st_width <= 4'h0;
         st_flsb <= 4'h0;
         st_data <= 8'h00;
         st_wait <= 4'h0;
         tgt_addr <= '0;
         tgt_rd <= 1'b0;
         tgt_wr <= 1'b0;
         tgt_wdata <= 16'h0000;
         last_step_executed <= '0;
         sequencer_running_flag <= 1'b0;
      end else if (stop_current_sequence && state != ST_IDLE) begin
         state <= ST_IDLE;
         tgt_rd <= 1'b0;
         tgt_wr <= 1'b0;
         sequencer_running_flag <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (q_pop) begin
                  cur_idx <= queue[q_rd];
                  state <= ST_FETCH;
                  sequencer_running_flag <= 1'b1;
               end
            end
            ST_FETCH: state <= ST_LOAD;
            ST_LOAD: begin
               tgt_addr <= mem_bus.seq_data[STEP_ADDR_LSB +: TGT_AW];
               st_width <= {1'b0, mem_bus.seq_data[STEP_WIDTH_LSB +: 3]} + 4'h1;
               st_data <= mem_bus.seq_data[STEP_DATA_LSB +: 8];
               st_flsb <= mem_bus.seq_data[STEP_FLSB_LSB +: 4];
               st_wait <= mem_bus.seq_data[STEP_WAIT_LSB +: WAIT_W];
               wait_cnt <= wait_cycles(mem_bus.seq_data[STEP_WAIT_LSB +: WAIT_W]);
               tgt_rd <= 1'b1;
               state <= ST_READ;
            end
            ST_READ: begin
               tgt_rd <= 1'b0;
               wait_cnt <= wait_cnt - 1'b1;
               state <= ST_MODIFY;
            end
            ST_MODIFY: begin
               tgt_wdata <= (tgt_rdata & ~field_mask) |
                            ((16'(st_data) << st_flsb) & field_mask);
               tgt_wr <= 1'b1;
               last_step_executed <= cur_idx;
               wait_cnt <= wait_cnt - 1'b1;
               state <= ST_WAIT;
            end
            ST_WAIT: begin
               tgt_wr <= 1'b0;
               if (wait_cnt <= CNT_W'(3)) begin
                  if (seq_end) begin
                     state <= ST_IDLE;
                     sequencer_running_flag <= 1'b0;
                  end else begin
                     cur_idx <= cur_idx + 1'b1;
                     state <= ST_FETCH;
                  end
               end else begin
                  wait_cnt <= wait_cnt - 1'b1;
               end
            end
            default: begin
               state <= ST_IDLE;
               sequencer_running_flag <= 1'b0;
            end
         endcase
      end
   end

   // sticky done flag when the queue runs dry; a new set beats the clear
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         seq_done_flag <= 1'b0;
      end else if (state == ST_WAIT && wait_cnt <= CNT_W'(3) && seq_end &&
                   !stop_current_sequence && q_cnt == '0 && !q_push) begin
         seq_done_flag <= 1'b1;
      end else if (seq_done_clear) begin
         seq_done_flag <= 1'b0;
      end
   end
endmodule

// ===== tb/cws_seq_properties.sv
// port-level assertions for the control write sequencer
`timescale 1ns/1ps
module cws_seq_props (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic reg_rd,
   input wire logic reg_rvalid,
   input wire logic stop_current_sequence,
   input wire logic sequencer_running_flag,
   input wire logic seq_done_flag,
   input wire logic seq_done_clear,
   input wire logic tgt_rd,
   input wire logic tgt_wr
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////
   // register port answer timing
   read_answer_a: assert property (reg_rd |-> ##2 reg_rvalid)
      else $error("read answer late");
   answer_cause_a: assert property (reg_rvalid |-> $past(reg_rd, 2))
      else $error("answer without read");
   // target accesses only inside a running sequence
   target_busy_a: assert property ((tgt_rd || tgt_wr) |-> sequencer_running_flag)
      else $error("target access while idle");
   write_after_read_a: assert property (tgt_wr |-> $past(tgt_rd, 2))
      else $error("write without read first");
   read_spacing_a: assert property (tgt_rd |=> !tgt_rd [*3])
      else $error("steps too close");
   fetch_to_read_a: assert property ($rose(sequencer_running_flag) && !stop_current_sequence
      ##1 !stop_current_sequence ##1 !stop_current_sequence |-> tgt_rd)
      else $error("first step read missing");
   // done flag set with the end of running, then sticky
   done_at_end_a: assert property ($rose(seq_done_flag) |-> $fell(sequencer_running_flag))
      else $error("done without end of run");
   done_sticky_a: assert property (seq_done_flag && !seq_done_clear |=> seq_done_flag)
      else $error("done flag dropped");
endmodule
bind cws_sequencer cws_seq_props chk_u (.core_clk(core_clk), .reset(reset), .reg_rd(reg_rd),
   .reg_rvalid(reg_rvalid), .stop_current_sequence(stop_current_sequence),
   .sequencer_running_flag(sequencer_running_flag), .seq_done_flag(seq_done_flag),
   .seq_done_clear(seq_done_clear), .tgt_rd(tgt_rd), .tgt_wr(tgt_wr));

// ===== tb/control_write_sequencer_bench.sv
// self-checking bench for the control write sequencer
`timescale 1ns/1ps
`define chk(n, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
   $display("mismatch %s expected %h seen %h", n, e, g); end end
module control_write_sequencer_bench import cws_pkg::*;;
   logic core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid;
   logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata, tgt_rdata = 16'h0000;
   logic sequencer_global_enable = 1'b1, host_launch_bit = 1'b0, stop_current_sequence = 1'b0;
   logic sequencer_running_flag, seq_done_flag, seq_done_clear = 1'b0, tgt_rd, tgt_wr, trd;
   logic audio_serial_port_slave = 1'b0, rate_estimation_enable = 1'b0;
   logic [1:0] out_path_ena = 2'h0, gpio_in = 2'h0;
   logic [3:0] rate_detect = 4'h0;
   logic [IDX_W-1:0] host_sequence_first_step = 9'h00A, last_step_executed;
   logic [IDX_W-1:0] rate_a_first_step = 9'h014, rate_b_first_step = 9'h00A;
   logic [IDX_W-1:0] rate_c_first_step = 9'h1FF, rate_d_first_step = 9'h1FF;
   logic [TGT_AW-1:0] tgt_addr;
   logic [15:0] tgt_wdata, tm [16], em [16], e_lo [512], e_hi [512];
   logic [28:0] wq [$];
   logic [31:0] rs = 32'h0000473A;
   int errors = 0, n_checks = 0, lastk;
   // clock keeps running all the time
   always #25 core_clk = ~core_clk;
   cws_sequencer #(.DELAY_UNIT(100)) dut_u (.core_clk(core_clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .sequencer_global_enable(sequencer_global_enable),
      .host_sequence_first_step(host_sequence_first_step), .host_launch_bit(host_launch_bit),
      .stop_current_sequence(stop_current_sequence),
      .sequencer_running_flag(sequencer_running_flag), .last_step_executed(last_step_executed),
      .seq_done_flag(seq_done_flag), .seq_done_clear(seq_done_clear),
      .out_path_ena(out_path_ena), .rate_a_first_step(rate_a_first_step),
      .rate_b_first_step(rate_b_first_step), .rate_c_first_step(rate_c_first_step),
      .rate_d_first_step(rate_d_first_step), .rate_detect(rate_detect),
      .audio_serial_port_slave(audio_serial_port_slave),
      .rate_estimation_enable(rate_estimation_enable), .gpio_in(gpio_in),
      .tgt_addr(tgt_addr), .tgt_rd(tgt_rd), .tgt_rdata(tgt_rdata), .tgt_wr(tgt_wr),
      .tgt_wdata(tgt_wdata));
   ////////////////////////////////////////
   // target registers answer the cycle after the read strobe; otherwise data toggles
   always @(posedge core_clk) begin
      trd = tgt_rd;
      if (tgt_wr) begin
         tm[tgt_addr[3:0]] <= tgt_wdata;
         wq.push_back({tgt_addr, tgt_wdata});
      end
      #1 tgt_rdata = trd ? tm[tgt_addr[3:0]] : ~tgt_rdata;
   end
   // random source
   function automatic logic [31:0] nxt();
      rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
      return rs;
   endfunction
   // expected merge of a step into an old register value
   function automatic logic [15:0] mrg(logic [15:0] o, logic [15:0] lo, logic [15:0] hi);
      logic [31:0] m;
      m = ((32'h1 << (32'(lo[15:13]) + 1)) - 1) << hi[11:8];
      return (o & ~m[15:0]) | 16'((32'(hi[7:0]) << hi[11:8]) & m);
   endfunction
   task automatic tick(int n = 1);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(logic [15:0] a, logic [15:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick();
      reg_wr = 1'b0;
      tick();
   endtask
   task automatic rd(logic [15:0] a, logic [15:0] e, string n);
      reg_addr = a;
      reg_rd = 1'b1;
      tick();
      reg_rd = 1'b0;
      tick();
      `chk(n, e, reg_rdata)
   endtask
   // store a random step with the given wait code
   task automatic prog(int i, logic [3:0] w);
      logic [31:0] r;
      r = nxt();
      e_lo[i] = {r[15:13], 9'h000, r[3:0]};
      e_hi[i] = {w, r[11:8], r[23:16]};
      wr(STEP_BASE_OFS + 16'(2 * i), e_lo[i]);
      wr(STEP_BASE_OFS + 16'(2 * i + 1), e_hi[i]);
   endtask
   task automatic step_ok(int i);
      logic [28:0] x;
      logic [15:0] e;
      x = wq.size() > 0 ? wq.pop_front() : 'x;
      e = mrg(em[e_lo[i][3:0]], e_lo[i], e_hi[i]);
      em[e_lo[i][3:0]] = e;
      `chk("step address", e_lo[i][12:0], x[28:16])
      `chk("step data", e, x[15:0])
   endtask
   task automatic seq_ok(int i);
      for (lastk = i; lastk < i + 8; lastk++) begin
         step_ok(lastk);
         if (e_hi[lastk][15:12] == WAIT_LAST_CODE) break;
      end
   endtask
   task automatic clr();
      wq.delete();
      seq_done_clear = 1'b1;
      tick();
      seq_done_clear = 1'b0;
   endtask
   // wait for the done flag, then compare the writes of one or two sequences
   task automatic runs(int a, int b);
      int k;
      for (k = 0; k < 4000 && seq_done_flag !== 1'b1; k++) tick();
      `chk("done flag", 1'b1, seq_done_flag)
      `chk("running flag", 1'b0, sequencer_running_flag)
      seq_ok(a);
      if (b >= 0) seq_ok(b);
      `chk("last step", 9'(lastk), last_step_executed)
      `chk("extra writes", 0, wq.size())
      clr();
   endtask
   task automatic none(string n);
      tick(60);
      `chk(n, 0, wq.size())
   endtask
   task automatic pulse_rate(logic [3:0] v);
      rate_detect = v;
      tick();
      rate_detect = 4'h0;
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #(50 * 40000);
      errors++;
      $display("mismatch watchdog expected finish seen hang");
      test_done();
   end
   ////////////////////////////////////////
   initial begin
      int i;
      logic [31:0] r;
      for (i = 0; i < 16; i++) begin
         r = nxt();
         tm[i] = r[15:0];
         em[i] = r[15:0];
      end
      tick(16);
      reset = 1'b0;
      tick();
      rd(GPIO_TRIG_ENA_OFS, 16'h0000, "enable reset");
      for (i = 0; i < 4; i++) rd(PIN1_RISE_OFS + 16'(i), 16'h01FF, "index reset");
      for (i = 0; i < 4; i++) begin
         r = nxt();
         wr(PIN1_RISE_OFS + 16'(i), r[15:0]);
         rd(PIN1_RISE_OFS + 16'(i), {7'h00, r[8:0]}, "index field");
      end
      wr(GPIO_TRIG_ENA_OFS, r[31:16]);
      rd(GPIO_TRIG_ENA_OFS, {14'h0000, r[17:16]}, "enable field");
      wr(16'h0050, 16'hFFFF);
      rd(16'h0050, 16'h0000, "unmapped");
      wr(GPIO_TRIG_ENA_OFS, 16'h0000);
      prog(10, 4'h0);
      prog(11, 4'hF);
      prog(20, 4'hF);
      prog(30, 4'h7);
      prog(31, 4'hF);
      prog(509, 4'hF);
      for (i = 0; i < 4; i++) prog(16 * i, 4'hF);
      rd(16'h33FA, e_lo[509], "last step low");
      rd(16'h33FB, e_hi[509], "last step high");
      $display("test registers done");
      clr();
      sequencer_global_enable = 1'b0;
      host_launch_bit = 1'b1;
      tick();
      host_launch_bit = 1'b0;
      none("launch disabled");
      sequencer_global_enable = 1'b1;
      host_launch_bit = 1'b1;
      tick();
      host_launch_bit = 1'b0;
      runs(10, -1);
      $display("test host done");
      wr(PIN1_RISE_OFS, 16'h000A);
      wr(PIN1_FALL_OFS, 16'h01FF);
      wr(PIN2_RISE_OFS, 16'h01FF);
      wr(PIN2_FALL_OFS, 16'h0014);
      gpio_in = 2'h2;
      tick(8);
      gpio_in = 2'h0;
      none("pin disabled");
      wr(GPIO_TRIG_ENA_OFS, 16'h0003);
      gpio_in = 2'h1;
      runs(10, -1);
      gpio_in = 2'h3;
      none("rise index off");
      gpio_in = 2'h1;
      runs(20, -1);
      gpio_in = 2'h0;
      none("fall index off");
      $display("test gpio done");
      pulse_rate(4'h3);
      none("rate not slave");
      audio_serial_port_slave = 1'b1;
      rate_estimation_enable = 1'b1;
      pulse_rate(4'hC);
      none("rate index off");
      pulse_rate(4'h3);
      runs(20, 10);
      $display("test rate done");
      for (i = 0; i < 2; i++) begin
         out_path_ena[i] = 1'b1;
         runs(16 * i, -1);
         out_path_ena[i] = 1'b0;
         runs(32 + 16 * i, -1);
      end
      $display("test paths done");
      wr(PIN1_RISE_OFS, 16'h001E);
      gpio_in = 2'h1;
      for (i = 0; i < 300 && wq.size() == 0; i++) tick();
      pulse_rate(4'h1);
      stop_current_sequence = 1'b1;
      tick();
      stop_current_sequence = 1'b0;
      step_ok(30);
      runs(20, -1);
      $display("test abort done");
      host_launch_bit = 1'b1;
      tick();
      host_launch_bit = 1'b0;
      tick(8);
      `chk("running before reset", 1'b1, sequencer_running_flag)
      reset = 1'b1;
      tick(2);
      reset = 1'b0;
      tick();
      `chk("running reset", 1'b0, sequencer_running_flag)
      rd(STEP_BASE_OFS + 16'h0014, e_lo[10], "kept low");
      rd(STEP_BASE_OFS + 16'h0015, e_hi[10], "kept high");
      rd(PIN1_RISE_OFS, 16'h01FF, "index reset again");
      $display("test second reset done");
      test_done();
   end
endmodule
